// [verilog/bgr_pkg.sv]
// Package for the banked general register file.
// Holds register numbers, status word field positions, mode codes and reset values.
package bgr_pkg;
   localparam int DATA_W = 16;
   localparam int REG_NUM_W = 3;
   localparam int BANK_SIZE = 6;
   localparam int PHYS_COUNT = 16;
   localparam int VISIBLE_COUNT = 8;
   // Status word field positions.
   localparam int STATUS_CUR_HI = 15;
   localparam int STATUS_CUR_LO = 14;
   localparam int STATUS_PREV_HI = 13;
   localparam int STATUS_PREV_LO = 12;
   localparam int STATUS_REGSET = 11;
   // Register numbers with a fixed role.
   localparam logic [2:0] REG_STACK = 3'h6;
   localparam logic [2:0] REG_PC = 3'h7;
   // Two-bit protection mode codes.
   localparam logic [1:0] MODE_KERNEL = 2'h0;
   localparam logic [1:0] MODE_SUPER = 2'h1;
   localparam logic [1:0] MODE_ILLEGAL = 2'h2;
   localparam logic [1:0] MODE_USER = 2'h3;
   // Reset values.
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   // Physical stack pointer index.
   typedef enum logic [2:0] {
      BGR_SP_KERNEL = 3'b001,
      BGR_SP_SUPER = 3'b010,
      BGR_SP_USER = 3'b100
   } bgr_sp_sel_t;
endpackage : bgr_pkg

// [verilog/bgr_sp_decode.sv]
// Decoder from a two-bit protection mode code to a one-hot stack pointer choice.
// Assumes a purely combinational use inside the register file.
`timescale 1ns/1ps
module bgr_sp_decode
   import bgr_pkg::*;
(
   input wire logic [1:0] mode,
   output bgr_sp_sel_t sel
);
   // Kernel, supervisor and user codes pick their own pointer; the illegal code picks user.
   always_comb begin
      case (mode)
         MODE_KERNEL: sel = BGR_SP_KERNEL;
         MODE_SUPER: sel = BGR_SP_SUPER;
         MODE_USER: sel = BGR_SP_USER;
         MODE_ILLEGAL: sel = BGR_SP_USER;
         default: sel = BGR_SP_USER;
      endcase
   end
endmodule : bgr_sp_decode

// [verilog/bgr_file.sv]
// Banked general register file of a 16-bit processor with per-mode stack pointers.
// Assumes the decode datapath gives register numbers, write strobes and the status word.
`timescale 1ns/1ps
// How it works
// - Sixteen physical registers exist, and eight are reachable by number at a time.
// - Numbers 0 to 5 go to the alternate bank when status bit 11 is set, else the primary.
// - Number six is the stack pointer, one of three physical pointers, one per mode.
// - Ordinary accesses choose the stack pointer by status bits 15 and 14.
// - Previous-space moves writing number six choose it by status bits 13 and 12.
// - The illegal mode code does not fault and reaches the user stack pointer.
// - Mode code 00 is kernel, 01 supervisor, 11 user and 10 illegal.
// - The previous-mode field is decoded with the same encoding as the current one.
// - Number seven is the single 16-bit program counter that sequences fetches.
// - The program counter reads and writes like any other general register operand.
// - Every visible register supports all addressing uses through two reads and a write.
module bgr_file
   import bgr_pkg::*;
#(
   parameter int WIDTH = DATA_W
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [15:0] processor_status_word,
   input wire logic instr_start,
   input wire logic prev_space_dest,
   input wire logic [2:0] rd_a_num,
   input wire logic [2:0] rd_b_num,
   input wire logic wr_en,
   input wire logic [2:0] wr_num,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic pc_inc,
   output logic [WIDTH-1:0] rd_a_data,
   output logic [WIDTH-1:0] rd_b_data,
   output logic [WIDTH-1:0] fetch_addr
);
   // Physical storage: two banks of six, three stack pointers, one counter.
   logic [WIDTH-1:0] primary_bank [BANK_SIZE];
   logic [WIDTH-1:0] alternate_bank [BANK_SIZE];
   logic [WIDTH-1:0] kernel_stack_ptr;
   logic [WIDTH-1:0] supervisor_stack_ptr;
   logic [WIDTH-1:0] user_stack_ptr;
   logic [WIDTH-1:0] program_counter;
   // Status fields latched at each instruction start.
   logic bank_sel;
   logic [1:0] cur_mode;
   logic [1:0] prev_mode;
   bgr_sp_sel_t cur_sp;
   bgr_sp_sel_t prev_sp;
   bgr_sp_sel_t wr_sp;
   logic [WIDTH-1:0] sp_cur_val;
   logic [WIDTH-1:0] next_pc;
   logic [WIDTH-1:0] next_rd_a;
   logic [WIDTH-1:0] next_rd_b;
   logic next_bank_sel;
   logic [1:0] next_cur_mode;
   logic [1:0] next_prev_mode;
   logic [WIDTH-1:0] pc_step;
   logic [WIDTH-1:0] bank_a_val;
   logic [WIDTH-1:0] bank_b_val;

   bgr_sp_decode u_cur_decode (
      .mode(cur_mode),
      .sel(cur_sp)
   );
   bgr_sp_decode u_prev_decode (
      .mode(prev_mode),
      .sel(prev_sp)
   );

   // New status fields are taken only when an instruction begins.
   assign next_bank_sel = instr_start ? processor_status_word[STATUS_REGSET] : bank_sel;
   assign next_cur_mode = instr_start ? processor_status_word[STATUS_CUR_HI:STATUS_CUR_LO]
                                      : cur_mode;
   assign next_prev_mode = instr_start ? processor_status_word[STATUS_PREV_HI:STATUS_PREV_LO]
                                       : prev_mode;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         bank_sel <= 1'b0;
         cur_mode <= MODE_KERNEL;
         prev_mode <= MODE_KERNEL;
      end else begin
         bank_sel <= next_bank_sel;
         cur_mode <= next_cur_mode;
         prev_mode <= next_prev_mode;
      end
   end

   // The write target pointer follows the previous mode only for previous-space moves.
   assign wr_sp = prev_space_dest ? prev_sp : cur_sp;
   // Current stack pointer as seen by reads.
   assign sp_cur_val = (cur_sp == BGR_SP_KERNEL) ? kernel_stack_ptr :
                       (cur_sp == BGR_SP_SUPER) ? supervisor_stack_ptr :
                       user_stack_ptr;

   // Read selection of one visible register by number, one mux per read port.
   // Numbers six and seven still index the bank mux past its six entries; the mux after it discards that value.
   assign bank_a_val = bank_sel ? alternate_bank[rd_a_num] : primary_bank[rd_a_num];
   assign bank_b_val = bank_sel ? alternate_bank[rd_b_num] : primary_bank[rd_b_num];
   assign next_rd_a = (rd_a_num == REG_PC) ? program_counter :
                      (rd_a_num == REG_STACK) ? sp_cur_val : bank_a_val;
   assign next_rd_b = (rd_b_num == REG_PC) ? program_counter :
                      (rd_b_num == REG_STACK) ? sp_cur_val : bank_b_val;
   assign pc_step = program_counter + WIDTH'(2);
   // An explicit write to number seven wins over the fetch increment.
   assign next_pc = (wr_en && wr_num == REG_PC) ? wr_data :
                    pc_inc ? pc_step : program_counter;

   // Bank registers, one per register number.
   for (genvar i = 0; i < BANK_SIZE; i++) begin : g_bank
      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            primary_bank[i] <= REG_RESET;
            alternate_bank[i] <= REG_RESET;
         end else if (wr_en && wr_num == 3'(i)) begin
            if (bank_sel) begin
               alternate_bank[i] <= wr_data;
            end else begin
               primary_bank[i] <= wr_data;
            end
         end
      end
   end

   // Stack pointers, counter and registered read ports.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         kernel_stack_ptr <= REG_RESET;
         supervisor_stack_ptr <= REG_RESET;
         user_stack_ptr <= REG_RESET;
         program_counter <= REG_RESET;
         rd_a_data <= REG_RESET;
         rd_b_data <= REG_RESET;
         fetch_addr <= REG_RESET;
      end else begin
         if (wr_en && wr_num == REG_STACK) begin
            case (wr_sp)
               BGR_SP_KERNEL: kernel_stack_ptr <= wr_data;
               BGR_SP_SUPER: supervisor_stack_ptr <= wr_data;
               BGR_SP_USER: user_stack_ptr <= wr_data;
               default: user_stack_ptr <= wr_data;
            endcase
         end
         program_counter <= next_pc;
         rd_a_data <= next_rd_a;
         rd_b_data <= next_rd_b;
         fetch_addr <= next_pc;
      end
   end

   // Register count check: banks, pointers and counter add up to the physical count.
   initial begin
      if (2 * BANK_SIZE + 4 != PHYS_COUNT || BANK_SIZE + 2 != VISIBLE_COUNT) begin
         $error("Register file geometry is inconsistent.");
      end
   end

   // Stack pointer writes through the current and the previous mode fields.
   kernel_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_en && wr_num == REG_STACK && !prev_space_dest && cur_mode == MODE_KERNEL
      |=> kernel_stack_ptr == $past(wr_data))
      else $error("Kernel pointer missed a write.");
   prev_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_en && wr_num == REG_STACK && prev_space_dest && prev_mode == MODE_SUPER
      |=> supervisor_stack_ptr == $past(wr_data) && $stable(kernel_stack_ptr))
      else $error("Previous-mode write went astray.");
   illegal_user_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_en && wr_num == REG_STACK && !prev_space_dest && cur_mode == MODE_ILLEGAL
      |=> user_stack_ptr == $past(wr_data))
      else $error("Illegal mode did not reach user pointer.");
   prev_illegal_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_en && wr_num == REG_STACK && prev_space_dest && prev_mode == MODE_ILLEGAL
      |=> user_stack_ptr == $past(wr_data) && $stable(kernel_stack_ptr))
      else $error("Previous illegal mode missed the user pointer.");

   // Read ports by register number and current mode.
   user_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rd_a_num == REG_STACK && cur_mode == MODE_USER ##1 1'b1
      |-> rd_a_data == $past(user_stack_ptr))
      else $error("User pointer read mismatch.");
   kernel_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rd_b_num == REG_STACK && cur_mode == MODE_KERNEL
      |=> rd_b_data == $past(kernel_stack_ptr))
      else $error("Kernel pointer read mismatch.");
   super_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rd_b_num == REG_STACK && cur_mode == MODE_SUPER
      |=> rd_b_data == $past(supervisor_stack_ptr))
      else $error("Supervisor pointer read mismatch.");
   illegal_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rd_a_num == REG_STACK && cur_mode == MODE_ILLEGAL |=> rd_a_data == $past(user_stack_ptr))
      else $error("Illegal mode read missed the user pointer.");
   prev_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rd_a_num == REG_STACK && prev_space_dest && cur_mode == MODE_KERNEL
      |=> rd_a_data == $past(kernel_stack_ptr))
      else $error("Stack read followed the previous mode.");
   primary_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rd_a_num == 3'h1 && !bank_sel |=> rd_a_data == $past(primary_bank[1]))
      else $error("Primary bank read mismatch.");
   bank_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rd_b_num == 3'h0 && bank_sel |=> rd_b_data == $past(alternate_bank[0]))
      else $error("Alternate bank read mismatch.");
   pc_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rd_a_num == REG_PC |=> rd_a_data == $past(program_counter))
      else $error("Counter read mismatch.");

   // Counter stepping, writes and holding, status latching and bank writes.
   pc_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
      pc_inc && !(wr_en && wr_num == REG_PC)
      |=> program_counter == $past(program_counter) + WIDTH'(2))
      else $error("Counter did not step by two.");
   pc_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_en && wr_num == REG_PC |=> fetch_addr == $past(wr_data) ##1 1'b1)
      else $error("Counter write lost.");
   pc_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !pc_inc && !(wr_en && wr_num == REG_PC) |=> $stable(program_counter))
      else $error("Counter moved without a step or write.");
   mode_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !instr_start |=> $stable(cur_mode) && $stable(bank_sel))
      else $error("Status fields changed mid instruction.");
   alt_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_en && wr_num == 3'h1 && bank_sel
      |=> alternate_bank[1] == $past(wr_data) && $stable(primary_bank[1]))
      else $error("Alternate bank write went astray.");
endmodule : bgr_file

// [testbench/bgr_dp_model.sv]
// Model of the decode datapath that drives the banked register file.
// Assumes the bench owns clock and reset; every change lands at a falling edge.
`timescale 1ns/1ps
module bgr_dp_model
   import bgr_pkg::*;
(
   input wire logic mclk,
   output logic [15:0] processor_status_word,
   output logic instr_start,
   output logic prev_space_dest,
   output logic [2:0] rd_a_num,
   output logic [2:0] rd_b_num,
   output logic wr_en,
   output logic [2:0] wr_num,
   output logic [15:0] wr_data,
   output logic pc_inc,
   input wire logic [15:0] rd_a_data,
   input wire logic [15:0] rd_b_data
);
   // Quiet request lines from time zero.
   initial begin
      processor_status_word = STATUS_RESET;
      {instr_start, prev_space_dest, wr_en, pc_inc} = 4'h0;
      {rd_a_num, rd_b_num, wr_num} = 9'h000;
      wr_data = 16'h0000;
   end
   // Presents a status word, with or without an instruction start pulse.
   task automatic start(input logic [15:0] status, input logic go);
      @(negedge mclk);
      processor_status_word = status;
      instr_start = go;
      @(negedge mclk);
      instr_start = 1'h0;
   endtask : start
   // One cycle of write strobe and counter step; data is scrambled once released.
   task automatic op(input logic we, input logic [2:0] num, input logic [15:0] d,
                     input logic prev, input logic inc);
      @(negedge mclk);
      {wr_en, prev_space_dest, pc_inc} = {we, prev, inc};
      wr_num = num;
      wr_data = d;
      @(negedge mclk);
      {wr_en, prev_space_dest, pc_inc} = 3'h0;
      wr_data = ~d;
   endtask : op
   // Two reads at once; data is taken one cycle after the numbers are presented.
   task automatic rd(input logic [2:0] a, input logic [2:0] b,
                     output logic [15:0] da, output logic [15:0] db);
      @(negedge mclk);
      rd_a_num = a;
      rd_b_num = b;
      @(negedge mclk);
      da = rd_a_data;
      db = rd_b_data;
   endtask : rd
endmodule : bgr_dp_model

// [testbench/banked_gpr_file_with_mode_stack_test.sv]
// Self-checking bench for the banked register file.
// Assumes the datapath model drives every request; the bench owns clock and reset.
`timescale 1ns/1ps
module banked_gpr_file_with_mode_stack_test;
   import bgr_pkg::*;
   typedef struct packed {
      logic [15:0] status; logic [2:0] num; logic [15:0] exp; logic [15:0] wd;
   } bgr_row_t;
   // Each row: status word, register read then written, expected old value, new value.
   localparam bgr_row_t rows[14] = '{
      '{16'h0000, 3'h1, 16'h0000, 16'h1111}, '{16'h0800, 3'h1, 16'h0000, 16'h2222},
      '{16'h0000, 3'h1, 16'h1111, 16'h1111}, '{16'h0000, 3'h6, 16'h0000, 16'h3333},
      '{16'h4000, 3'h6, 16'h0000, 16'h4444}, '{16'hC000, 3'h6, 16'h0000, 16'h5555},
      '{16'h8000, 3'h6, 16'h5555, 16'h6666}, '{16'hC000, 3'h6, 16'h6666, 16'h6666},
      '{16'h0000, 3'h6, 16'h3333, 16'h3333}, '{16'h4000, 3'h6, 16'h4444, 16'h4444},
      '{16'h0800, 3'h5, 16'h0000, 16'h7777}, '{16'h0000, 3'h5, 16'h0000, 16'h0000},
      '{16'h0800, 3'h0, 16'h0000, 16'h8888}, '{16'h0000, 3'h0, 16'h0000, 16'h0000}};
   logic mclk = 1'h0;
   logic sys_rst = 1'h1;
   logic [15:0] processor_status_word, wr_data, rd_a_data, rd_b_data, fetch_addr, da, db;
   logic instr_start, prev_space_dest, wr_en, pc_inc;
   logic [2:0] rd_a_num, rd_b_num, wr_num;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   // Clock at 200 MHz.
   always #2.5 mclk = ~mclk;
   bgr_dp_model bgr_dp_model_inst (.mclk(mclk), .processor_status_word(processor_status_word),
      .instr_start(instr_start), .prev_space_dest(prev_space_dest), .rd_a_num(rd_a_num),
      .rd_b_num(rd_b_num), .wr_en(wr_en), .wr_num(wr_num), .wr_data(wr_data), .pc_inc(pc_inc),
      .rd_a_data(rd_a_data), .rd_b_data(rd_b_data));
   bgr_file bgr_file_inst (.mclk(mclk), .sys_rst(sys_rst),
      .processor_status_word(processor_status_word), .instr_start(instr_start),
      .prev_space_dest(prev_space_dest), .rd_a_num(rd_a_num), .rd_b_num(rd_b_num),
      .wr_en(wr_en), .wr_num(wr_num), .wr_data(wr_data), .pc_inc(pc_inc),
      .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .fetch_addr(fetch_addr));
   // Compares one value and counts it.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Writes the stack slot picked by the previous mode, then reads it back as current.
   task automatic prev_case(input logic [15:0] pw, input logic [15:0] d, input logic [15:0] pr);
      bgr_dp_model_inst.start(pw, 1'h1);
      bgr_dp_model_inst.op(1'h1, 3'h6, d, 1'h1, 1'h0);
      bgr_dp_model_inst.start(pr, 1'h1);
      bgr_dp_model_inst.rd(3'h6, 3'h6, da, db);
      chk(da, d);
   endtask : prev_case
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   // Cuts a hang short well beyond the expected 141 cycles.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         stop_test();
      end
   end
   // Main sequence: reset, counter, table rows, then the awkward cases.
   initial begin
      repeat (3) @(negedge mclk);
      sys_rst = 1'h0;
      bgr_dp_model_inst.rd(3'h7, 3'h6, da, db);
      chk(da, REG_RESET);
      chk(db, REG_RESET);
      for (int i = 0; i < 3; i++) bgr_dp_model_inst.op(1'h0, 3'h0, 16'h0000, 1'h0, 1'h1);
      chk(fetch_addr, 16'h0006);
      bgr_dp_model_inst.op(1'h1, 3'h7, 16'h0100, 1'h0, 1'h0);
      bgr_dp_model_inst.rd(3'h7, 3'h7, da, db);
      chk(da, 16'h0100);
      chk(fetch_addr, 16'h0100);
      bgr_dp_model_inst.op(1'h1, 3'h7, 16'h0200, 1'h0, 1'h1);
      chk(fetch_addr, 16'h0200);
      foreach (rows[i]) begin
         bgr_dp_model_inst.start(rows[i].status, 1'h1);
         bgr_dp_model_inst.rd(rows[i].num, rows[i].num, da, db);
         chk(da, rows[i].exp);
         chk(db, rows[i].exp);
         bgr_dp_model_inst.op(1'h1, rows[i].num, rows[i].wd, 1'h0, 1'h0);
      end
      bgr_dp_model_inst.start(16'h0800, 1'h0);
      bgr_dp_model_inst.rd(3'h1, 3'h6, da, db);
      chk(da, 16'h1111);
      chk(db, 16'h3333);
      bgr_dp_model_inst.start(16'h8800, 1'h1);
      bgr_dp_model_inst.rd(3'h1, 3'h7, da, db);
      chk(da, 16'h2222);
      chk(db, 16'h0200);
      prev_case(16'h3000, 16'hABCD, 16'hC000);
      bgr_dp_model_inst.start(16'h0000, 1'h1);
      bgr_dp_model_inst.rd(3'h6, 3'h6, da, db);
      chk(da, 16'h3333);
      prev_case(16'h1000, 16'hBEEF, 16'h4000);
      prev_case(16'h2000, 16'h1234, 16'hC000);
      @(negedge mclk);
      sys_rst = 1'h1;
      @(negedge mclk);
      sys_rst = 1'h0;
      bgr_dp_model_inst.rd(3'h1, 3'h6, da, db);
      chk(da, REG_RESET);
      chk(fetch_addr, REG_RESET);
      stop_test();
   end
endmodule : banked_gpr_file_with_mode_stack_test
